// ### verilog/pbfs_pin_mux.v
// Purpose: port b pin function multiplexer with apb control registers
// Assumes: apb inputs synchronous to clk_in; reset_in is the external power-on reset
// Notes: watchdog, standby and sleep never reach this block, so state survives them
`default_nettype none
`include "pbfs_defs.vh"

module pbfs_pin_mux #(
   parameter REDUCED_PIN = 0,
   parameter NPINS = 10,
   parameter PC_PINS = 16
) (
   input wire clk_in,
   input wire reset_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,
   input wire single_chip_in,
   input wire rom_disabled_in,
   input wire [NPINS-1:0] pb_gpio_dir_in,
   input wire [NPINS-1:0] pb_gpio_data_in,
   input wire [NPINS-1:0] pb_pin_in,
   input wire [21:16] addr_in,
   input wire bus_rw_direction_in,
   input wire row_strobe_in,
   input wire col_strobe_high_in,
   input wire col_strobe_low_in,
   input wire [PC_PINS-1:0] pc_gpio_sel_in,
   output wire [NPINS-1:0] pb_pin_out,
   output wire [NPINS-1:0] pb_pin_oe_out,
   output reg [NPINS-1:0] pb_gpio_sel_out,
   output reg [5:0] ext_int_req_out,
   output reg wait_req_out,
   output reg [PC_PINS-1:0] pc_pin_oe_out
);

   // ==========================================================
   // register state
   // the upper 16 bits of every register word are unused and read as zero
   reg [15:0] func_high_q;
   reg [15:0] func_low_q;
   reg [15:0] pc_dir_q;
   reg [15:0] rd_val;
   reg hit;
   wire [15:0] low_mask;
   wire setup_phase;
   wire access_done;

   // on the reduced-pin variant bits 2 and 0 are masked as well, and the
   // address roles of pins 1 and 0 below are disabled; their cells stay
   // so the port width is the same for both builds
   assign low_mask = (REDUCED_PIN != 0) ? `PBFS_MASK_FUNC_LOW_RED
                                        : `PBFS_MASK_FUNC_LOW;
   assign setup_phase = psel_in & ~penable_in;
   assign access_done = psel_in & penable_in & pready_out;

   // ==========================================================
   // address decode and read view
   always @* begin
      hit = 1'b1;
      rd_val = `PBFS_RESET_16;
      case (paddr_in)
         `PBFS_ADDR_FUNC_HIGH: rd_val = func_high_q;
         `PBFS_ADDR_FUNC_LOW: rd_val = func_low_q;
         `PBFS_ADDR_PC_DIR: rd_val = pc_dir_q;
         default: hit = 1'b0;
      endcase
   end

   // ==========================================================
   // apb answer: one wait-free access phase, data sampled in setup
   // registering the answer costs nothing since setup always precedes access
   // so the access phase always completes in its first cycle; a master that
   // skips setup gets no answer at all
   // prdata keeps its last value until the next setup, which is harmless
   // because a master only takes it together with pready
   always @(posedge clk_in) begin
      if (reset_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h00000000;
      end else if (setup_phase) begin
         pready_out <= 1'b1;
         pslverr_out <= ~hit;
         prdata_out <= (hit & ~pwrite_in) ? {16'h0000, rd_val} : 32'h00000000;
      end else begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
   end

   // ==========================================================
   // register writes; reserved and missing bits are masked to zero
   // writes commit only at the completing access edge, so a request that
   // is dropped during setup leaves every register untouched
   always @(posedge clk_in) begin
      if (reset_in) begin
         func_high_q <= `PBFS_RESET_16;
         func_low_q <= `PBFS_RESET_16;
         pc_dir_q <= `PBFS_RESET_16;
      end else if (access_done & pwrite_in) begin
         case (paddr_in)
            `PBFS_ADDR_FUNC_HIGH:
               func_high_q <= pwdata_in[15:0] & `PBFS_MASK_FUNC_HIGH;
            `PBFS_ADDR_FUNC_LOW:
               func_low_q <= pwdata_in[15:0] & low_mask;
            `PBFS_ADDR_PC_DIR:
               pc_dir_q <= pwdata_in[15:0] & `PBFS_MASK_PC_DIR;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // role decode per pin: general i/o, alternate output, or input role
   // pin role map by pin number:
   //   pin 9: gpio, ext_int_req_7 in, addr_bit_21 out
   //   pin 8: gpio, ext_int_req_6 in, addr_bit_20 out, wait request in
   //   pin 7: gpio, addr_bit_19 out
   //   pin 6: gpio, addr_bit_18 out
   //   pin 5: gpio, ext_int_req_3 in, bus read/write direction out
   //   pin 4: gpio, ext_int_req_2 in, col_strobe_high out
   //   pin 3: gpio, ext_int_req_1 in, col_strobe_low out
   //   pin 2: gpio, ext_int_req_0 in, row strobe out
   //   pin 1: gpio, addr_bit_17 out
   //   pin 0: gpio, addr_bit_16 out
   // input roles leave the pin undriven; the pin level then reaches its
   // request line one clock later
   reg [NPINS-1:0] gpio_sel;
   reg [NPINS-1:0] alt_sel;
   reg [NPINS-1:0] alt_val;
   reg [5:0] irq_sel;
   reg wait_sel;
   wire [1:0] md9;
   wire [1:0] md8;
   wire [1:0] md7;
   wire [1:0] md6;
   wire [1:0] md5;
   wire [1:0] md4;
   wire [1:0] md3;
   wire [1:0] md2;
   wire md1;
   wire md0;
   wire ext_bus;

   assign md9 = func_high_q[`PBFS_PIN9_HI:`PBFS_PIN9_LO];
   assign md8 = func_high_q[`PBFS_PIN8_HI:`PBFS_PIN8_LO];
   assign md7 = func_low_q[`PBFS_PIN7_HI:`PBFS_PIN7_LO];
   assign md6 = func_low_q[`PBFS_PIN6_HI:`PBFS_PIN6_LO];
   assign md5 = func_low_q[`PBFS_PIN5_HI:`PBFS_PIN5_LO];
   assign md4 = func_low_q[`PBFS_PIN4_HI:`PBFS_PIN4_LO];
   assign md3 = func_low_q[`PBFS_PIN3_HI:`PBFS_PIN3_LO];
   assign md2 = func_low_q[`PBFS_PIN2_HI:`PBFS_PIN2_LO];
   assign md1 = func_low_q[`PBFS_PIN1_BIT];
   assign md0 = func_low_q[`PBFS_PIN0_BIT];
   // bus roles exist only while the external bus is active
   // single-chip mode is a level; changing it at run time drops bus roles
   // on the next edge without touching the stored codes, so leaving the
   // mode brings them back
   assign ext_bus = ~single_chip_in;

   // an interrupt role claims the pin as input only; it never sets alt_sel,
   // so the pin cell keeps its enable low
   always @* begin
      alt_sel = {NPINS{1'b0}};
      alt_val = {NPINS{1'b0}};
      irq_sel = 6'h00;
      wait_sel = 1'b0;
      // pin 9
      if (md9 == `PBFS_MD_01) irq_sel[5] = 1'b1;
      if (md9 == `PBFS_MD_10 && ext_bus) begin
         alt_sel[9] = 1'b1;
         alt_val[9] = addr_in[21];
      end
      // pin 8
      if (md8 == `PBFS_MD_01) irq_sel[4] = 1'b1;
      if (md8 == `PBFS_MD_10 && ext_bus) begin
         alt_sel[8] = 1'b1;
         alt_val[8] = addr_in[20];
      end
      if (md8 == `PBFS_MD_11 && ext_bus) wait_sel = 1'b1;
      // pins 7 and 6: only code 10 leaves general i/o
      if (md7 == `PBFS_MD_10 && ext_bus) begin
         alt_sel[7] = 1'b1;
         alt_val[7] = addr_in[19];
      end
      if (md6 == `PBFS_MD_10 && ext_bus) begin
         alt_sel[6] = 1'b1;
         alt_val[6] = addr_in[18];
      end
      // pins 5 to 2: interrupt input, or bus read/write direction (pin 5) or bus strobe (pins 4 to 2)
      if (md5 == `PBFS_MD_01) irq_sel[3] = 1'b1;
      if (md5 == `PBFS_MD_11 && ext_bus) begin
         alt_sel[5] = 1'b1;
         alt_val[5] = bus_rw_direction_in;
      end
      if (md4 == `PBFS_MD_01) irq_sel[2] = 1'b1;
      if (md4 == `PBFS_MD_11 && ext_bus) begin
         alt_sel[4] = 1'b1;
         alt_val[4] = col_strobe_high_in;
      end
      if (md3 == `PBFS_MD_01) irq_sel[1] = 1'b1;
      if (md3 == `PBFS_MD_11 && ext_bus) begin
         alt_sel[3] = 1'b1;
         alt_val[3] = col_strobe_low_in;
      end
      if (md2 == `PBFS_MD_01) irq_sel[0] = 1'b1;
      if (md2 == `PBFS_MD_11 && ext_bus) begin
         alt_sel[2] = 1'b1;
         alt_val[2] = row_strobe_in;
      end
      // pins 1 and 0: rom-disabled mode makes them address even at 0
      // booting from outside needs these address bits before software runs,
      // so the override does not wait for a register write
      if (ext_bus && (md1 || rom_disabled_in) && REDUCED_PIN == 0) begin
         alt_sel[1] = 1'b1;
         alt_val[1] = addr_in[17];
      end
      if (ext_bus && (md0 || rom_disabled_in) && REDUCED_PIN == 0) begin
         alt_sel[0] = 1'b1;
         alt_val[0] = addr_in[16];
      end
   end

   // ==========================================================
   // a pin is general i/o unless a valid role claims it; reserved codes
   // claim nothing and so fall back here
   always @* begin
      gpio_sel = ~alt_sel;
      gpio_sel[9] = gpio_sel[9] & ~irq_sel[5];
      gpio_sel[8] = gpio_sel[8] & ~irq_sel[4] & ~wait_sel;
      gpio_sel[5] = gpio_sel[5] & ~irq_sel[3];
      gpio_sel[4] = gpio_sel[4] & ~irq_sel[2];
      gpio_sel[3] = gpio_sel[3] & ~irq_sel[1];
      gpio_sel[2] = gpio_sel[2] & ~irq_sel[0];
   end

   // ==========================================================
   // pin driver stages
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
         pbfs_pin_cell u_cell (
            .clk_in(clk_in),
            .reset_in(reset_in),
            .gpio_sel_in(gpio_sel[gi]),
            .alt_out_sel_in(alt_sel[gi]),
            .alt_val_in(alt_val[gi]),
            .gpio_dir_in(pb_gpio_dir_in[gi]),
            .gpio_data_in(pb_gpio_data_in[gi]),
            .pin_out(pb_pin_out[gi]),
            .pin_oe_out(pb_pin_oe_out[gi])
         );
      end
   endgenerate

   // ==========================================================
   // routed inputs, role flags and port c enables, all registered;
   // unselected interrupt and wait lines read as idle zero
   // role flags are registered with the pin stages so both show a role
   // change on the same edge
   // port c: a direction bit reaches the pin only while that pin reports
   // general i/o; otherwise the enable stays low
   always @(posedge clk_in) begin
      if (reset_in) begin
         pb_gpio_sel_out <= {NPINS{1'b1}};
         ext_int_req_out <= 6'h00;
         wait_req_out <= 1'b0;
         pc_pin_oe_out <= {PC_PINS{1'b0}};
      end else begin
         pb_gpio_sel_out <= gpio_sel;
         ext_int_req_out <= irq_sel & {pb_pin_in[9:8], pb_pin_in[5:2]};
         wait_req_out <= wait_sel & pb_pin_in[8];
         pc_pin_oe_out <= pc_dir_q & pc_gpio_sel_in;
      end
   end

endmodule // pbfs_pin_mux

`default_nettype wire

// ### verilog/pbfs_defs.vh
// Purpose: shared constants of the port b pin function select block
// Assumes: included by bare name from the block's design files
// Notes: definitions only
`ifndef PBFS_DEFS_VH
`define PBFS_DEFS_VH

// ==========================================================
// register byte addresses on the apb slave
`define PBFS_ADDR_FUNC_HIGH 12'h000
`define PBFS_ADDR_FUNC_LOW 12'h004
`define PBFS_ADDR_PC_DIR 12'h008
`define PBFS_ADDR_W 12

// ==========================================================
// reset values and writable-bit masks
`define PBFS_RESET_16 16'h0000
`define PBFS_MASK_FUNC_HIGH 16'h000F
`define PBFS_MASK_FUNC_LOW 16'hFFF5
`define PBFS_MASK_FUNC_LOW_RED 16'hFFF0
`define PBFS_MASK_PC_DIR 16'hFFFF

// ==========================================================
// field positions
`define PBFS_PIN9_HI 3
`define PBFS_PIN9_LO 2
`define PBFS_PIN8_HI 1
`define PBFS_PIN8_LO 0
`define PBFS_PIN7_HI 15
`define PBFS_PIN7_LO 14
`define PBFS_PIN6_HI 13
`define PBFS_PIN6_LO 12
`define PBFS_PIN5_HI 11
`define PBFS_PIN5_LO 10
`define PBFS_PIN4_HI 9
`define PBFS_PIN4_LO 8
`define PBFS_PIN3_HI 7
`define PBFS_PIN3_LO 6
`define PBFS_PIN2_HI 5
`define PBFS_PIN2_LO 4
`define PBFS_PIN1_BIT 2
`define PBFS_PIN0_BIT 0

// ==========================================================
// two-bit mode codes
`define PBFS_MD_GPIO 2'h0
`define PBFS_MD_01 2'h1
`define PBFS_MD_10 2'h2
`define PBFS_MD_11 2'h3

`endif

// ### verilog/pbfs_pin_cell.v
// Purpose: one port b pin driver stage, registered output value and enable
// Assumes: role decode is done by the parent; one clock, synchronous reset
// Notes: alternate output wins over general i/o; neither means pin undriven
`default_nettype none

module pbfs_pin_cell (
   input wire clk_in,
   input wire reset_in,
   input wire gpio_sel_in,
   input wire alt_out_sel_in,
   input wire alt_val_in,
   input wire gpio_dir_in,
   input wire gpio_data_in,
   output reg pin_out,
   output reg pin_oe_out
);

   // ==========================================================
   // output stage: registered so every top output starts at a flop
   always @(posedge clk_in) begin
      if (reset_in) begin
         pin_out <= 1'b0;
         pin_oe_out <= 1'b0;
      end else if (alt_out_sel_in) begin
         pin_out <= alt_val_in;
         pin_oe_out <= 1'b1;
      end else begin
         pin_out <= gpio_data_in;
         pin_oe_out <= gpio_sel_in & gpio_dir_in; // direction only counts as i/o
      end
   end

endmodule // pbfs_pin_cell

`default_nettype wire

// ### sim/pbfs_ext_model.sv
// Purpose: far side of port b, interrupt sources and bus devices on the pins
// Assumes: the device drives a pin only while its enable is high
// Notes: an undriven pin shows the level the outside source puts on it
`default_nettype none
// ==========================================
// pin level model
module pbfs_ext_model (
   input wire logic [9:0] pin_in,
   input wire logic [9:0] oe_in,
   input wire logic [9:0] src_in,
   output logic [9:0] level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // device wins where it drives, else the outside source sets the level
   assign level_out = (oe_in & pin_in) | (~oe_in & src_in);
endmodule // pbfs_ext_model
`default_nettype wire

// ### sim/pbfs_pin_mux_monitor.sv
// Purpose: port-level checks of the port b pin mux
// Assumes: bound to pbfs_pin_mux, one clock domain
// Notes: pin path outputs lag their causes by one clock
`default_nettype none
// ==========================================
// checker
module pbfs_pin_mux_monitor #(
   parameter NPINS = 10,
   parameter PC_PINS = 16
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic single_chip_in,
   input wire logic [NPINS-1:0] pb_pin_in,
   input wire logic [21:16] addr_in,
   input wire logic bus_rw_direction_in,
   input wire logic row_strobe_in,
   input wire logic [PC_PINS-1:0] pc_gpio_sel_in,
   input wire logic [NPINS-1:0] pb_pin_out,
   input wire logic [NPINS-1:0] pb_pin_oe_out,
   input wire logic [NPINS-1:0] pb_gpio_sel_out,
   input wire logic [5:0] ext_int_req_out,
   input wire logic wait_req_out,
   input wire logic [PC_PINS-1:0] pc_pin_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // read completion seen by the master
   wire logic rd_ack = pready_out && !pwrite_in;
   AST_READY: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no ready after setup");
   AST_UNMAPPED: assert property (pready_out && paddr_in > 12'h008 |-> pslverr_out)
      else $error("unmapped access without error");
   AST_HIGH_RSV: assert property (
      rd_ack && paddr_in == 12'h000 |-> prdata_out[15:4] == 12'h000)
      else $error("high reserved bits read nonzero");
   AST_LOW_RSV: assert property (
      rd_ack && paddr_in == 12'h004 |-> !prdata_out[3] && !prdata_out[1])
      else $error("low reserved bits read nonzero");
   // single-chip mode: no pin outside general i/o may drive
   AST_SC_NODRV: assert property (
      $past(single_chip_in) |-> (pb_pin_oe_out & ~pb_gpio_sel_out) == 0)
      else $error("bus role drives in single-chip mode");
   AST_EXT_INT_REQ_7: assert property (
      ext_int_req_out[5] |-> !pb_gpio_sel_out[9] && $past(pb_pin_in[9]))
      else $error("ext_int_req_7 without its pin");
   AST_WAIT: assert property (wait_req_out |-> $past(pb_pin_in[8]) && !$past(single_chip_in))
      else $error("wait request wrongly raised");
   AST_A21: assert property (
      pb_pin_oe_out[9] && !pb_gpio_sel_out[9] |-> pb_pin_out[9] == $past(addr_in[21]))
      else $error("pin 9 not carrying address");
   AST_BUS_RW_DIRECTION: assert property (
      pb_pin_oe_out[5] && !pb_gpio_sel_out[5] |-> pb_pin_out[5] == $past(bus_rw_direction_in))
      else $error("pin 5 not carrying read/write");
   AST_ROW: assert property (
      pb_pin_oe_out[2] && !pb_gpio_sel_out[2] |-> pb_pin_out[2] == $past(row_strobe_in))
      else $error("pin 2 not carrying row strobe");
   AST_PC_OE: assert property ((pc_pin_oe_out & ~$past(pc_gpio_sel_in)) == 0)
      else $error("port c drives outside general i/o");
   AST_RST: assert property ($past(reset_in) |-> &pb_gpio_sel_out && pc_pin_oe_out == 0)
      else $error("state not cleared by reset");
   COV_WAIT: cover property (wait_req_out);
   COV_IRQ: cover property (ext_int_req_out[5]);
   COV_ERR: cover property (pslverr_out);
endmodule // pbfs_pin_mux_monitor
bind pbfs_pin_mux pbfs_pin_mux_monitor #(.NPINS(NPINS), .PC_PINS(PC_PINS)) u_mon (
   .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .single_chip_in(single_chip_in),
   .pb_pin_in(pb_pin_in), .addr_in(addr_in), .bus_rw_direction_in(bus_rw_direction_in),
   .row_strobe_in(row_strobe_in), .pc_gpio_sel_in(pc_gpio_sel_in), .pb_pin_out(pb_pin_out),
   .pb_pin_oe_out(pb_pin_oe_out), .pb_gpio_sel_out(pb_gpio_sel_out),
   .ext_int_req_out(ext_int_req_out), .wait_req_out(wait_req_out),
   .pc_pin_oe_out(pc_pin_oe_out));
`default_nettype wire

// ### sim/pbfs_pin_mux_tb_top.sv
// Purpose: self-checking bench of the port b pin mux
// Assumes: apb answer time is not assumed, pins lag registers by one clock
// Notes: irq sources held high so selected requests read as one
`default_nettype none
// ==========================================
// bench top
module pbfs_pin_mux_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0, prdata_out;
   logic pready_out, pslverr_out, wait_req_out;
   logic single_chip_in = 1'b0, rom_disabled_in = 1'b0, rw_q = 1'b1, row_q = 1'b0;
   logic [9:0] pin_q, oe_q, sel_q, lvl_w, src_q = 10'h3FF;
   logic [5:0] irq_q, addr_q = 6'h2A;
   logic [15:0] pc_sel_q = 16'h00FF, pc_oe_q;
   logic [31:0] prdata_r;
   logic [9:0] sel_r;
   int err_count = 0, checks_done = 0;
   // 125 MHz clock
   always #4 clk_in = ~clk_in;
   pbfs_pin_mux DUT (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .single_chip_in(single_chip_in),
      .rom_disabled_in(rom_disabled_in), .pb_gpio_dir_in(10'h3FF), .pb_gpio_data_in(10'h155),
      .pb_pin_in(lvl_w), .addr_in(addr_q), .bus_rw_direction_in(rw_q), .row_strobe_in(row_q),
      .col_strobe_high_in(1'b1), .col_strobe_low_in(1'b0), .pc_gpio_sel_in(pc_sel_q),
      .pb_pin_out(pin_q), .pb_pin_oe_out(oe_q), .pb_gpio_sel_out(sel_q),
      .ext_int_req_out(irq_q), .wait_req_out(wait_req_out), .pc_pin_oe_out(pc_oe_q));
   // reduced-pin build shares the bus; its read view and pins 1 and 0 are judged
   pbfs_pin_mux #(.REDUCED_PIN(1)) DUT_RED (.clk_in(clk_in), .reset_in(reset_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_r), .pready_out(), .pslverr_out(),
      .single_chip_in(single_chip_in), .rom_disabled_in(rom_disabled_in),
      .pb_gpio_dir_in(10'h3FF), .pb_gpio_data_in(10'h155), .pb_pin_in(lvl_w),
      .addr_in(addr_q), .bus_rw_direction_in(rw_q), .row_strobe_in(row_q),
      .col_strobe_high_in(1'b1), .col_strobe_low_in(1'b0), .pc_gpio_sel_in(pc_sel_q),
      .pb_pin_out(), .pb_pin_oe_out(), .pb_gpio_sel_out(sel_r), .ext_int_req_out(),
      .wait_req_out(), .pc_pin_oe_out());
   pbfs_ext_model u_ext (.pin_in(pin_q), .oe_in(oe_q), .src_in(src_q), .level_out(lvl_w));
   // ==========================================
   // shared tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer; waits for pready however long it takes
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      // no latency assumed: only the watchdog ends a hung wait
      do begin
         @(posedge clk_in);
      end while (pready_out !== 1'b1);
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic end_of_test();
      if (err_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_regs();
      logic [31:0] q;
      logic e;
      logic [11:0] ad [3] = '{12'h000, 12'h004, 12'h008};
      logic [15:0] mk [3] = '{16'h000F, 16'hFFF5, 16'hFFFF};
      logic [15:0] rk [3] = '{16'h000F, 16'hFFF0, 16'hFFFF};
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, ad[i], 32'h0, q, e);
         chk("reset value", 32'h0, q);
         apb(1'b1, ad[i], 32'hFFFFFFFF, q, e);
         apb(1'b0, ad[i], 32'h0, q, e);
         chk("readback", {16'h0000, mk[i]}, q);
         chk("reduced readback", {16'h0000, rk[i]}, prdata_r);
         apb(1'b1, ad[i], 32'h0, q, e);
      end
      apb(1'b1, 12'h00C, 32'hFFFFFFFF, q, e);
      chk("unmapped error", 32'h1, {31'h0, e});
   endtask
   // every code of both high fields, in normal and single-chip mode
   task automatic t_high();
      logic [31:0] q;
      logic e;
      logic [1:0] c;
      logic g9, g8, a9;
      logic [3:0] dr;
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            single_chip_in <= s[0];
            apb(1'b1, 12'h000, {28'h0, c, c}, q, e);
            repeat (3) @(posedge clk_in);
            g9 = c == 0 || c == 3 || (c == 2 && s == 1);
            g8 = c == 0 || (c[1] && s == 1);
            a9 = c == 2 && s == 0;
            // gpio data is 1 on pin 8, 0 on pin 9; address bits 21 and 20 are 1 and 0
            dr = {c != 1, !(c == 1 || (c == 3 && s == 0)), a9, !a9};
            chk("pin9 gpio", {31'h0, g9}, {31'h0, sel_q[9]});
            chk("pin8 gpio", {31'h0, g8}, {31'h0, sel_q[8]});
            chk("pin9 pin8 drive", {28'h0, dr}, {28'h0, oe_q[9:8], pin_q[9:8]});
            chk("ext_int_req_7 ext_int_req_6", {30'h0, c == 1, c == 1}, {30'h0, irq_q[5:4]});
            chk("wait", {31'h0, c == 3 && s == 0}, {31'h0, wait_req_out});
         end
      end
   endtask
   // every code of the low fields at once, reserved codes included
   task automatic t_low();
      logic [31:0] q;
      logic e;
      logic [1:0] c;
      logic al, bu, ad, st;
      logic [7:0] gl, eo, pe;
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            single_chip_in <= s[0];
            apb(1'b1, 12'h004, {16'h0, {6{c}}, 1'b0, c[0], 1'b0, c[0]}, q, e);
            repeat (3) @(posedge clk_in);
            al = c == 2 && s == 0;
            bu = c == 1 || (c == 3 && s == 0);
            ad = c[0] && s == 0;
            st = c == 3 && s == 0;
            gl = ~{al, al, bu, bu, bu, bu, ad, ad};
            eo = {2'b11, {4{c != 1}}, 2'b11};
            // low gpio data is 8'h55; strobe sources for pins 5 to 2 are 1, 1, 0, 0
            pe = {al, !al, st, 1'b1, 1'b0, !st, ad, !ad};
            chk("low sel", {24'h0, gl}, {24'h0, sel_q[7:0]});
            chk("low oe", {24'h0, eo}, {24'h0, oe_q[7:0]});
            chk("low pins", {24'h0, pe}, {24'h0, pin_q[7:0]});
            chk("ext_int_req_3..0", {28'h0, {4{c == 1}}}, {28'h0, irq_q[3:0]});
         end
      end
   endtask
   // rom-disabled mode turns pins 1 and 0 into address at code zero
   task automatic t_rom();
      logic [31:0] q;
      logic e;
      rom_disabled_in <= 1'b1;
      for (int s = 0; s < 2; s++) begin
         single_chip_in <= s[0];
         apb(1'b1, 12'h004, 32'h0, q, e);
         repeat (3) @(posedge clk_in);
         chk("rom pins", {30'h0, s[0], s[0]}, {30'h0, sel_q[1:0]});
         chk("reduced rom pins", 32'h3, {30'h0, sel_r[1:0]});
      end
   endtask
   // port c enables follow direction only where the pin is general i/o
   task automatic t_pc();
      logic [31:0] q;
      logic e;
      apb(1'b1, 12'h008, 32'h0F0F, q, e);
      repeat (3) @(posedge clk_in);
      chk("pc oe part", 32'h000F, {16'h0, pc_oe_q});
      pc_sel_q <= 16'hFFFF;
      repeat (3) @(posedge clk_in);
      chk("pc oe all", 32'h0F0F, {16'h0, pc_oe_q});
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk_in);
      reset_in <= 1'b0;
      t_regs();
      t_high();
      t_low();
      t_rom();
      t_pc();
      end_of_test();
   end
   // watchdog, far beyond the 164 cycles the run needs
   initial begin
      #200000;
      err_count++;
      end_of_test();
   end
endmodule // pbfs_pin_mux_tb_top
`default_nettype wire
